// file: hw/shcp_port.sv
// spi host/client serial port with avalon register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module shcp_port
    import shcp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic ss_n_in,
    input wire logic timer_tick_in,
    output logic transfer_flag_out
);
    logic wait_reg, en_reg, ckp_reg, smp_reg, cke_reg, write_collision_reg, ovf_reg;
    logic full_reg, flag_reg, samp_reg, pend_reg, sck_reg, sck_prev_reg;
    logic sdo_oe_reg, sck_oe_reg;
    logic [3:0] mode_reg;
    logic [7:0] rdata_reg, ctrl3_reg, baud_reg, buf_reg, shift_reg;
    logic [2:0] cnt_reg;
    logic [4:0] ph_reg;
    shcp_state_t state_reg;
    logic [2:0] pins_sync;
    logic tick;
    logic [1:0] hs_pipe_reg;

    // true for the modes in which this end makes the clock
    function automatic logic is_host(input logic [3:0] mode);
        is_host = (mode == MODE_DIV4) || (mode == MODE_DIV16) || (mode == MODE_DIV64) ||
            (mode == MODE_TIMER) || (mode == MODE_BAUD);
    endfunction

    shcp_sync #(.WIDTH(3)) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .async_in({sck_in, sdi_in, ss_n_in}),
        .sync_out(pins_sync)
    );
    wire sck_sync = pins_sync[2];
    wire sdi_sync = pins_sync[1];
    wire ss_sync = pins_sync[0];

    // bus decode: one wait cycle, then the request is taken
    wire req = avs_read_in | avs_write_in;
    wire take = req & ~wait_reg;
    wire rd_take = take & avs_read_in;
    wire wr_lane = take & avs_write_in & avs_byteenable_in[0];
    wire [7:0] wdata = avs_writedata_in[7:0];
    wire sel_buf = (avs_address_in == OFF_BUFFER);
    wire wr_stat = wr_lane & (avs_address_in == OFF_STATUS);
    wire wr_ctrl1 = wr_lane & (avs_address_in == OFF_CTRL1);
    wire wr_flag = wr_lane & (avs_address_in == OFF_FLAG);

    // role and select decode
    wire host_mode = is_host(mode_reg);
    wire client_mode = (mode_reg == MODE_CLIENT_SS) || (mode_reg == MODE_CLIENT);
    wire ss_ctl = (mode_reg == MODE_CLIENT_SS);
    wire selected = !ss_ctl || !ss_sync;
    wire mod_reset = !en_reg || (client_mode && ss_ctl && ss_sync);
    wire client_run = en_reg && client_mode && selected;

    // host rate selection
    wire [8:0] baud_p1 = {1'b0, baud_reg} + 9'h001;
    wire [9:0] half_sel = (mode_reg == MODE_DIV16) ? HALF_DIV16 :
        (mode_reg == MODE_DIV64) ? HALF_DIV64 :
        (mode_reg == MODE_BAUD) ? {baud_p1, 1'b0} : HALF_DIV4;

    shcp_baud u_baud (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .run_in(en_reg && host_mode && (state_reg == ST_RUN)),
        .use_timer_in(mode_reg == MODE_TIMER),
        .timer_tick_in(timer_tick_in),
        .half_in(half_sel),
        .tick_out(tick)
    );

    // serial clock events: host from ticks, client from the pin
    wire host_ev = en_reg && host_mode && (state_reg == ST_RUN) && tick;
    wire client_ev = client_run && (sck_sync != sck_prev_reg);
    wire client_lead = (sck_prev_reg == ckp_reg);
    wire host_par = ~(cke_reg ^ smp_reg);
    wire host_samp = (ph_reg[0] == host_par) && !(ph_reg == 5'h00 && smp_reg);
    wire sample_ev = hs_pipe_reg[1] ||
        (client_ev && (client_lead == cke_reg));
    wire shift_ev = ((host_ev && !host_samp) || (client_ev && !sample_ev)) &&
        (pend_reg || sample_ev);
    wire byte_done = sample_ev && (cnt_reg == LAST_BIT) && en_reg;
    wire [7:0] rx_byte = {shift_reg[6:0], sdi_sync};
    wire [4:0] ph_last = (smp_reg && !cke_reg) ? PH_LAST_SMP : PH_LAST;

    // buffer write outcome
    wire busy = (state_reg == ST_RUN) || (cnt_reg != 3'h0) || pend_reg;
    wire write_ok = wr_lane && sel_buf && !busy && !write_collision_reg;
    wire collide = wr_lane && sel_buf && busy && en_reg;

    // read data select; the shift register has no address
    wire [7:0] rd_mux = (avs_address_in == OFF_STATUS) ?
            {smp_reg, cke_reg, 5'h00, full_reg} :
        (avs_address_in == OFF_CTRL1) ? {write_collision_reg, ovf_reg, en_reg, ckp_reg, mode_reg} :
        (avs_address_in == OFF_CTRL3) ? ctrl3_reg :
        sel_buf ? buf_reg :
        (avs_address_in == OFF_BAUD) ? baud_reg :
        (avs_address_in == OFF_FLAG) ? {7'h00, flag_reg} : RST_BYTE;

    // avalon handshake and read data
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wait_reg <= 1'b1;
            rdata_reg <= RST_BYTE;
        end else begin
            wait_reg <= ~(req & wait_reg);
            if (req && wait_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // configuration registers
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            en_reg <= 1'b0;
            ckp_reg <= 1'b0;
            mode_reg <= RST_MODE;
            smp_reg <= 1'b0;
            cke_reg <= 1'b0;
            ctrl3_reg <= RST_BYTE;
            baud_reg <= RST_BYTE;
        end else begin
            if (wr_ctrl1) begin
                en_reg <= wdata[CTRL_EN];
                ckp_reg <= wdata[CTRL_CKP];
                mode_reg <= wdata[CTRL_MODE_HI:0];
            end
            if (wr_stat) begin
                smp_reg <= wdata[STAT_SMP];
                cke_reg <= wdata[STAT_CKE];
            end
            if (wr_lane && avs_address_in == OFF_CTRL3) begin
                ctrl3_reg <= wdata;
            end
            if (wr_lane && avs_address_in == OFF_BAUD) begin
                baud_reg <= wdata;
            end
        end
    end

    // sticky flags: hardware set wins over software clear
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            full_reg <= 1'b0;
            flag_reg <= 1'b0;
            write_collision_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            full_reg <= byte_done || (full_reg && !(rd_take && sel_buf));
            flag_reg <= byte_done || (flag_reg && !(wr_flag && !wdata[FLAG_DONE]));
            write_collision_reg <= collide || (write_collision_reg && !(wr_ctrl1 && !wdata[CTRL_WRITE_COLLISION]));
            ovf_reg <= (byte_done && full_reg && client_mode) ||
                (ovf_reg && !(wr_ctrl1 && !wdata[CTRL_OVF]));
        end
    end

    // data buffer and shift register
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            buf_reg <= RST_BYTE;
            shift_reg <= RST_BYTE;
            samp_reg <= 1'b0;
            pend_reg <= 1'b0;
            cnt_reg <= 3'h0;
        end else if (write_ok) begin
            buf_reg <= wdata;
            shift_reg <= wdata;
        end else if (mod_reset) begin
            pend_reg <= 1'b0;
            cnt_reg <= 3'h0;
        end else if (byte_done) begin
            buf_reg <= rx_byte;
            shift_reg <= rx_byte;
            pend_reg <= 1'b0;
            cnt_reg <= 3'h0;
        end else if (sample_ev) begin
            samp_reg <= sdi_sync;
            pend_reg <= !shift_ev;
            cnt_reg <= cnt_reg + 3'h1;
            if (shift_ev) begin
                shift_reg <= {shift_reg[6:0], sdi_sync};
            end
        end else if (shift_ev) begin
            shift_reg <= {shift_reg[6:0], samp_reg};
            pend_reg <= 1'b0;
        end
    end

    // host sequencer: sixteen clock half periods per word
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            ph_reg <= 5'h00;
            sck_reg <= 1'b0;
        end else if (!en_reg || !host_mode) begin
            state_reg <= ST_IDLE;
            ph_reg <= 5'h00;
            sck_reg <= ckp_reg;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    sck_reg <= ckp_reg;
                    ph_reg <= 5'h00;
                    if (write_ok) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        if (!ph_reg[4]) begin
                            sck_reg <= ~sck_reg;
                        end
                        if (ph_reg == ph_last) begin
                            state_reg <= ST_IDLE;
                        end
                        ph_reg <= ph_reg + 5'h01;
                    end
                end
            endcase
        end
    end

    // pin ownership, client clock history, host sample delay
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            hs_pipe_reg <= 2'h0;
            sck_prev_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            sck_oe_reg <= 1'b0;
        end else begin
            hs_pipe_reg <= {hs_pipe_reg[0], host_ev && host_samp}; // waits out sdi sync
            sck_prev_reg <= sck_sync;
            sdo_oe_reg <= en_reg && (host_mode || client_run);
            sck_oe_reg <= en_reg && host_mode;
        end
    end

    assign avs_waitrequest_out = wait_reg;
    assign avs_readdata_out = {24'h000000, rdata_reg};
    assign sck_out = sck_reg;
    assign sck_oe_out = sck_oe_reg;
    assign sdo_out = shift_reg[7];
    assign sdo_oe_out = sdo_oe_reg;
    assign transfer_flag_out = flag_reg;

    // helper: serial clock toggles in one host word
    logic [4:0] tog_cnt;
    always_ff @(posedge core_clk_in) begin
        if (reset_in || state_reg == ST_IDLE) begin
            tog_cnt <= 5'h00;
        end else if (tick && !ph_reg[4]) begin
            tog_cnt <= tog_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_deselect;
        en_reg && client_mode && ss_ctl && ss_sync;
    endsequence

    rx_capture_a: assert property (byte_done |=>
        full_reg && flag_reg && buf_reg == $past(rx_byte))
        else $error("received byte not captured with flags");
    write_load_a: assert property (write_ok |=>
        buf_reg == $past(wdata) && shift_reg == $past(wdata))
        else $error("buffer write did not load both registers");
    collide_flag_a: assert property (collide |=> write_collision_reg &&
        (buf_reg == $past(buf_reg) || $past(byte_done))) else $error("collision not flagged");
    write_collision_block_a: assert property ((wr_lane && sel_buf && write_collision_reg && !busy) |=>
        buf_reg == $past(buf_reg) && shift_reg == $past(shift_reg))
        else $error("write completed while collision flag set");
    read_clear_a: assert property ((rd_take && sel_buf && !byte_done) |=> !full_reg)
        else $error("buffer read left buffer full set");
    host_start_a: assert property ((write_ok && en_reg && host_mode) |=>
        state_reg == ST_RUN ##1 busy)
        else $error("host transfer did not start on write");
    host_eight_a: assert property ($fell(state_reg == ST_RUN) && en_reg |->
        tog_cnt == PH_TOGGLES && sck_reg == ckp_reg)
        else $error("host word not sixteen clock edges");
    disable_reset_a: assert property (!en_reg |=> cnt_reg == 3'h0 && !pend_reg
        && !sdo_oe_reg && !sck_oe_reg)
        else $error("disabled port not reset");
    deselect_a: assert property (s_deselect |=> !sdo_oe_reg && cnt_reg == 3'h0)
        else $error("deselected client still active");
    unselected_a: assert property ((client_mode && !selected) |-> !byte_done ##1
        !sdo_oe_reg)
        else $error("unselected client drove or counted");
    quiet_off_a: assert property (!en_reg |-> !byte_done && !collide)
        else $error("disabled port raised a flag");
endmodule
`default_nettype wire

// file: hw/shcp_pkg.sv
// constants and types shared by the spi host/client port
package shcp_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_CTRL1 = 5'h04;
    localparam logic [4:0] OFF_CTRL3 = 5'h08;
    localparam logic [4:0] OFF_BUFFER = 5'h0C;
    localparam logic [4:0] OFF_BAUD = 5'h10;
    localparam logic [4:0] OFF_FLAG = 5'h14;
    // status_reg field positions
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_FULL = 0;
    // control_reg_one and flag register field positions
    localparam int CTRL_WRITE_COLLISION = 7;
    localparam int CTRL_OVF = 6;
    localparam int CTRL_EN = 5;
    localparam int CTRL_CKP = 4;
    localparam int CTRL_MODE_HI = 3;
    localparam int FLAG_DONE = 0;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_MODE = 4'h0;
    // mode field encodings
    localparam logic [3:0] MODE_DIV4 = 4'h0;
    localparam logic [3:0] MODE_DIV16 = 4'h1;
    localparam logic [3:0] MODE_DIV64 = 4'h2;
    localparam logic [3:0] MODE_TIMER = 4'h3;
    localparam logic [3:0] MODE_CLIENT_SS = 4'h4;
    localparam logic [3:0] MODE_CLIENT = 4'h5;
    localparam logic [3:0] MODE_BAUD = 4'hA;
    // system clocks per serial clock half period
    localparam logic [9:0] HALF_DIV4 = 10'h002;
    localparam logic [9:0] HALF_DIV16 = 10'h008;
    localparam logic [9:0] HALF_DIV64 = 10'h020;
    // bit and phase counts of one word
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [4:0] PH_LAST = 5'h0F;
    localparam logic [4:0] PH_LAST_SMP = 5'h10;
    localparam logic [4:0] PH_TOGGLES = 5'h10;
    typedef enum logic {ST_IDLE, ST_RUN} shcp_state_t;
endpackage

// file: hw/shcp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module shcp_sync #(
    parameter int WIDTH = 3
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// file: hw/shcp_baud.sv
// half period tick generator for the host serial clock
`timescale 1ns/1ps
`default_nettype none
module shcp_baud (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic run_in,
    input wire logic use_timer_in,
    input wire logic timer_tick_in,
    input wire logic [9:0] half_in,
    output logic tick_out
);
    logic [9:0] cnt_reg;
    wire cnt_wrap = (cnt_reg == half_in - 10'h001);

    // one pulse per half period, or per timer pulse
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !run_in) begin
            cnt_reg <= 10'h000;
            tick_out <= 1'b0;
        end else if (use_timer_in) begin
            cnt_reg <= 10'h000;
            tick_out <= timer_tick_in;
        end else begin
            cnt_reg <= cnt_wrap ? 10'h000 : cnt_reg + 10'h001;
            tick_out <= cnt_wrap;
        end
    end
endmodule
`default_nettype wire

// file: sim/shcp_client_model.sv
// behavioural spi client that faces the port while it is in host role
`timescale 1ns/1ps
`default_nettype none
module shcp_client_model (
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic sel_n_in,
    input wire logic [7:0] load_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic [7:0] tx_reg = 8'h00;
    logic [3:0] nrx_reg = 4'h0;
    logic [2:0] nsh_reg = 3'h0;
    // word to send is captured when the host selects us
    always @(negedge sel_n_in) begin
        tx_reg <= load_in;
    end
    // latch on the trailing (falling) edge, msb arrives first into lsb
    always @(negedge sck_in or posedge sel_n_in) begin
        if (sel_n_in) begin
            nrx_reg <= 4'h0;
        end else begin
            rx_out <= {rx_out[6:0], mosi_in};
            nrx_reg <= nrx_reg + 4'h1;
        end
    end
    // shift out on the leading edge, first lead skipped since msb already shows
    always @(posedge sck_in or posedge sel_n_in) begin
        if (sel_n_in) begin
            nsh_reg <= 3'h0;
        end else if (nrx_reg != 4'h0) begin
            nsh_reg <= nsh_reg + 3'h1;
        end
    end
    // unselected: no real data, show the inverse of the last bit driven
    assign miso_out = sel_n_in ? ~tx_reg[0] : tx_reg[3'h7 - nsh_reg];
endmodule
`default_nettype wire

// file: sim/tb_shcp_port.sv
// self-checking testbench for the spi host/client port
`timescale 1ns/1ps
`default_nettype none
module tb_shcp_port;
    import shcp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] addr = 5'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq, sck_out, sck_oe, sdo, sdo_oe, flag_out, part_sdo;
    logic tb_sck = 1'b0;
    logic tb_ss_n = 1'b1;
    logic tb_sdi = 1'b0;
    logic tick = 1'b0;
    logic host_role = 1'b1;
    logic part_sel_n = 1'b1;
    logic [7:0] part_load = 8'h00;
    logic [7:0] part_rx, got, rx;
    logic sck_q = 1'b0;
    int cyc = 0, last_rise = 0, prev_rise = 0, n_rise = 0, tcnt = 0, base;
    int n_mismatch = 0, total_checks = 0;
    wire sck_pin = sck_oe ? sck_out : tb_sck;
    wire sdi_pin = host_role ? part_sdo : tb_sdi;
    logic [4:0] offs [7] = '{OFF_STATUS, OFF_CTRL1, OFF_CTRL3, OFF_BUFFER, OFF_BAUD, OFF_FLAG, 5'h18};
    logic [3:0] modes [5] = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_TIMER, MODE_BAUD};
    int rise_gap [5] = '{4, 16, 64, 10, 12};

    shcp_port shcp_port_i (.core_clk_in(clk), .reset_in(rst), .avs_address_in(addr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .sck_in(sck_pin), .sck_out(sck_out), .sck_oe_out(sck_oe), .sdi_in(sdi_pin),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .ss_n_in(tb_ss_n), .timer_tick_in(tick),
        .transfer_flag_out(flag_out));
    shcp_client_model shcp_client_model_i (.sck_in(sck_out), .mosi_in(sdo),
        .sel_n_in(part_sel_n), .load_in(part_load), .miso_out(part_sdo), .rx_out(part_rx));

    // 50 ns system clock
    initial begin
        forever #25 clk = ~clk;
    end
    // timer pulse every 5 clocks, rising edges of the serial clock timed
    always @(posedge clk) begin
        tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
        tick <= (tcnt == 4);
        cyc <= cyc + 1;
        sck_q <= sck_out;
        if (sck_out === 1'b1 && sck_q === 1'b0) begin
            prev_rise <= last_rise;
            last_rise <= cyc;
            n_rise <= n_rise + 1;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one avalon access: hold until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        rx = rdata[7:0];
        chk(rdata[31:8], 24'h0);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rx, e);
    endtask
    task automatic wait_flag;
        while (flag_out !== 1'b1) @(posedge clk);
    endtask
    // host-role word against the client model
    task automatic host_word(input logic [7:0] tx, input logic [7:0] pl);
        part_load <= pl;
        part_sel_n <= 1'b0;
        base = n_rise;
        bus(1'b1, OFF_BUFFER, tx);
        wait_flag();
        rd_chk(OFF_STATUS, 8'h01);
        bus(1'b0, OFF_BUFFER, 8'h00);
        got = rx;
        chk(n_rise - base, 8);
        bus(1'b1, OFF_FLAG, 8'h00);
        part_sel_n <= 1'b1;
        @(posedge clk);
    endtask
    // the bench as bus host for client role, sdi moved well clear of the sampling edge
    task automatic host_xfer(input logic [7:0] tx, input int nb, input logic sel);
        tb_ss_n <= !sel;
        for (int i = 0; i < nb; i++) begin
            tb_sdi <= tx[7-i];
            repeat (4) @(posedge clk);
            tb_sck <= 1'b1;
            repeat (8) @(posedge clk);
            rx = {rx[6:0], sdo};
            tb_sck <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        tb_ss_n <= 1'b1;
        // deselect held long enough to pass the select synchroniser
        repeat (4) @(posedge clk);
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (offs[i]) rd_chk(offs[i], 8'h00);
        bus(1'b1, OFF_STATUS, 8'hFF);
        rd_chk(OFF_STATUS, 8'hC0);
        bus(1'b1, OFF_CTRL3, 8'hA5);
        rd_chk(OFF_CTRL3, 8'hA5);
        bus(1'b1, OFF_BAUD, 8'h02);
        rd_chk(OFF_BAUD, 8'h02);
        bus(1'b1, 5'h18, 8'hFF);
        rd_chk(5'h18, 8'h00);
        bus(1'b1, OFF_STATUS, 8'h00);
        // disabled port stays idle after a buffer write
        base = n_rise;
        bus(1'b1, OFF_CTRL1, 8'h01);
        bus(1'b1, OFF_BUFFER, 8'h42);
        repeat (100) @(posedge clk);
        chk({flag_out, sck_oe, sdo_oe}, 3'h0);
        chk(n_rise - base, 0);
        rd_chk(OFF_CTRL1, 8'h01);
        // host exchange with a collision before the first serial clock edge of the word
        bus(1'b1, OFF_CTRL1, 8'h21);
        repeat (2) @(posedge clk);
        chk({sck_oe, sdo_oe}, 2'h3);
        part_load <= 8'h5A;
        part_sel_n <= 1'b0;
        bus(1'b1, OFF_BUFFER, 8'hC3);
        bus(1'b1, OFF_BUFFER, 8'h11);
        rd_chk(OFF_CTRL1, 8'hA1);
        wait_flag();
        rd_chk(OFF_FLAG, 8'h01);
        rd_chk(OFF_BUFFER, 8'h5A);
        chk(part_rx, 8'hC3);
        rd_chk(OFF_STATUS, 8'h00);
        bus(1'b1, OFF_FLAG, 8'h00);
        part_sel_n <= 1'b1;
        base = n_rise;
        bus(1'b1, OFF_BUFFER, 8'h77);
        repeat (60) @(posedge clk);
        chk(n_rise - base, 0);
        rd_chk(OFF_BUFFER, 8'h5A);
        bus(1'b1, OFF_CTRL1, 8'h21);
        host_word(8'h96, 8'h3C);
        chk(got, 8'h3C);
        chk(part_rx, 8'h96);
        // every host rate, reconfigured through disable
        foreach (modes[i]) begin
            bus(1'b1, OFF_CTRL1, {4'h0, modes[i]});
            bus(1'b1, OFF_CTRL1, {4'h2, modes[i]});
            host_word(8'h0F, 8'hF0);
            chk(got, 8'hF0);
            chk(last_rise - prev_rise, rise_gap[i]);
        end
        // client role with select
        host_role <= 1'b0;
        bus(1'b1, OFF_CTRL1, {4'h0, MODE_CLIENT_SS});
        bus(1'b1, OFF_CTRL1, {4'h2, MODE_CLIENT_SS});
        bus(1'b1, OFF_BUFFER, 8'hE1);
        repeat (4) @(posedge clk);
        chk({sck_oe, sdo_oe}, 2'h0);
        host_xfer(8'hFF, 8, 1'b0);
        chk(flag_out, 1'b0);
        host_xfer(8'h3D, 8, 1'b1);
        wait_flag();
        chk(rx, 8'hE1);
        rd_chk(OFF_BUFFER, 8'h3D);
        bus(1'b1, OFF_FLAG, 8'h00);
        host_xfer(8'hAA, 3, 1'b1);
        chk(sdo_oe, 1'b0);
        host_xfer(8'h81, 8, 1'b1);
        wait_flag();
        rd_chk(OFF_BUFFER, 8'h81);
        final_report();
    end
endmodule
`default_nettype wire
